// ==== pms_core.sv ====
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - master emits a one-cycle period-start pulse whenever the period counter starts or restarts.
// - transfer-indicate pulse accompanies start pulse only when a shadow copy happened.
// - programmable delay sits between counter start and both outgoing pulses.
// - slave synchronises its period counter to the incoming period-start pulse.
// - slave loads shadow registers as the incoming transfer-indicate pulse says, and from a pending copy at its first start after enable.
// - three capture inputs, indexed zero to two, capture the period counter.
// - six modulated match outputs, indexed zero to five.
// - prescale and period counters run on the same clock as the control interface.
// - sixteen-bit period counter advanced by a sixteen-bit prescale counter.
// - protective stop input holds outputs at software-set levels, optionally flags interrupt.
// - modules chain, each instance may be master of the next one.
module pms_core
  import pms_pkg::*;
(
  input  wire logic                        i_clock,          // modulator branch clock, also control clock
  input  wire logic                        i_sys_rst,        // async reset, active high
  input  wire logic                        i_enable,         // counters run when high
  input  wire logic                        i_slave_mode,     // follow upstream sync pulses
  input  wire logic [pms_pkg::CNT_W-1:0]   i_prescale,       // prescale terminal value
  input  wire logic [pms_pkg::CNT_W-1:0]   i_period,         // staged period terminal value
  input  wire logic [pms_pkg::NUM_MAT*pms_pkg::CNT_W-1:0] i_rise, // staged rise points
  input  wire logic [pms_pkg::NUM_MAT*pms_pkg::CNT_W-1:0] i_fall, // staged fall points
  input  wire logic                        i_update_req,     // software asks for shadow copy
  input  wire logic [pms_pkg::DLY_W-1:0]   i_sync_delay,     // delay of outgoing sync pair
  input  wire logic [pms_pkg::NUM_MAT-1:0] i_trap_level,     // output levels while stopped
  input  wire logic                        i_trap_int_en,    // allow stop interrupt
  input  wire logic                        i_trap_clear,     // leave protective state
  input  wire logic                        i_sync_in,        // upstream period-start pulse
  input  wire logic                        i_xfer_in,        // upstream transfer-indicate pulse
  input  wire logic [pms_pkg::NUM_CAP-1:0] i_capture_inputs, // capture pins
  input  wire logic                        i_protective_stop_input, // stop pin
  output logic [pms_pkg::NUM_MAT-1:0]      o_modulated_outputs, // match outputs
  output logic                             o_sync_out,       // period-start pulse to next stage
  output logic                             o_xfer_out,       // transfer-indicate pulse to next stage
  output logic [pms_pkg::NUM_CAP*pms_pkg::CNT_W-1:0] o_capture_value, // captured counts
  output logic [pms_pkg::NUM_CAP-1:0]      o_capture_event,  // one-cycle capture strobe
  output logic                             o_trapped,        // protective state active
  output logic                             o_trap_irq,       // stop interrupt level
  output logic                             o_update_pending  // shadow copy still waiting
);
  import pms_pkg::*;

  // pins from outside pass two flops; the first stage is read only by the second
  logic [NUM_CAP-1:0] cap_s1_r, cap_s2_r, cap_s3_r;
  logic               trp_s1_r, trp_s2_r;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cap_s1_r <= '0;
      cap_s2_r <= '0;
      cap_s3_r <= '0;
      trp_s1_r <= 1'b0;
      trp_s2_r <= 1'b0;
    end else begin
      cap_s1_r <= i_capture_inputs;
      cap_s2_r <= cap_s1_r;
      cap_s3_r <= cap_s2_r;
      trp_s1_r <= i_protective_stop_input;
      trp_s2_r <= trp_s1_r;
    end
  end

  // counters, shadows and pending copy
  logic [CNT_W-1:0]         pre_r, pre_nxt;
  logic [CNT_W-1:0]         cnt_r, cnt_nxt;
  logic [CNT_W-1:0]         per_sh_r, per_sh_nxt;
  logic [NUM_MAT*CNT_W-1:0] rise_sh_r, rise_sh_nxt;
  logic [NUM_MAT*CNT_W-1:0] fall_sh_r, fall_sh_nxt;
  logic                     pend_r, pend_nxt;
  logic                     run_r, run_nxt;
  logic                     start, xfer, wrap;

  // wrap is the master restart; in slave mode the counter waits for upstream
  assign wrap = (pre_r == i_prescale) && (cnt_r == per_sh_r);

  always_comb begin
    pre_nxt     = pre_r;
    cnt_nxt     = cnt_r;
    per_sh_nxt  = per_sh_r;
    rise_sh_nxt = rise_sh_r;
    fall_sh_nxt = fall_sh_r;
    pend_nxt    = pend_r | i_update_req;
    run_nxt     = i_enable;
    start       = 1'b0;
    xfer        = 1'b0;
    if (!i_enable) begin
      pre_nxt = CNT_ZERO;
      cnt_nxt = CNT_ZERO;
    end else if (i_slave_mode && i_sync_in) begin
      pre_nxt = CNT_ZERO;
      cnt_nxt = CNT_ZERO;
      start   = 1'b1;
      xfer    = i_xfer_in;
    end else if (!run_r || (!i_slave_mode && wrap)) begin
      pre_nxt = CNT_ZERO;
      cnt_nxt = CNT_ZERO;
      start   = 1'b1;
      xfer    = pend_r | i_update_req;
    end else if (pre_r == i_prescale) begin
      pre_nxt = CNT_ZERO;
      if (cnt_r != per_sh_r) begin
        cnt_nxt = cnt_r + CNT_ONE;
      end
    end else begin
      pre_nxt = pre_r + CNT_ONE;
    end
    if (xfer) begin
      per_sh_nxt  = i_period;
      rise_sh_nxt = i_rise;
      fall_sh_nxt = i_fall;
      pend_nxt    = 1'b0;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pre_r     <= CNT_ZERO;
      cnt_r     <= CNT_ZERO;
      per_sh_r  <= CNT_ZERO;
      rise_sh_r <= '0;
      fall_sh_r <= '0;
      pend_r    <= 1'b0;
      run_r     <= 1'b0;
    end else begin
      pre_r     <= pre_nxt;
      cnt_r     <= cnt_nxt;
      per_sh_r  <= per_sh_nxt;
      rise_sh_r <= rise_sh_nxt;
      fall_sh_r <= fall_sh_nxt;
      pend_r    <= pend_nxt;
      run_r     <= run_nxt;
    end
  end

  // outgoing pair feeds the next instance's slave inputs
  pms_sync_delay i_pms_sync_delay (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_delay   (i_sync_delay),
    .i_start   (start),
    .i_xfer    (xfer),
    .o_sync    (o_sync_out),
    .o_xfer    (o_xfer_out)
  );

  // protective state: set wins over clear so a stop is never lost
  logic trap_r, trap_nxt;
  always_comb begin
    trap_nxt = trap_r;
    if (i_trap_clear) begin
      trap_nxt = 1'b0;
    end
    if (trp_s2_r) begin
      trap_nxt = 1'b1;
    end
  end

  // match outputs and captures, one per index
  logic [NUM_MAT-1:0]       mat_r, mat_nxt;
  logic [NUM_CAP*CNT_W-1:0] capv_r, capv_nxt;
  logic [NUM_CAP-1:0]       cape_r, cape_nxt;

  genvar g;
  generate
    for (g = 0; g < NUM_MAT; g++) begin : g_mat
      always_comb begin
        mat_nxt[g] = mat_r[g];
        if (trap_r) begin
          mat_nxt[g] = i_trap_level[g];
        end else if (!i_enable) begin
          mat_nxt[g] = MAT_RESET[g];
        end else if (cnt_r == fall_sh_r[g*CNT_W +: CNT_W]) begin
          mat_nxt[g] = 1'b0;
        end else if (cnt_r == rise_sh_r[g*CNT_W +: CNT_W]) begin
          mat_nxt[g] = 1'b1;
        end
      end
    end
    for (g = 0; g < NUM_CAP; g++) begin : g_cap
      always_comb begin
        cape_nxt[g]                 = cap_s2_r[g] & ~cap_s3_r[g];
        capv_nxt[g*CNT_W +: CNT_W]  = cape_nxt[g] ? cnt_r : capv_r[g*CNT_W +: CNT_W];
      end
    end
  endgenerate

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      trap_r <= 1'b0;
      mat_r  <= MAT_RESET;
      capv_r <= '0;
      cape_r <= '0;
    end else begin
      trap_r <= trap_nxt;
      mat_r  <= mat_nxt;
      capv_r <= capv_nxt;
      cape_r <= cape_nxt;
    end
  end

  assign o_modulated_outputs = mat_r;
  assign o_capture_value     = capv_r;
  assign o_capture_event     = cape_r;
  assign o_trapped           = trap_r;
  assign o_trap_irq          = trap_r & i_trap_int_en;
  assign o_update_pending    = pend_r;

  sequence s_slave_sync;
    i_enable && i_slave_mode && i_sync_in;
  endsequence

  property p_slave_restart;
    @(posedge i_clock) disable iff (i_sys_rst)
    s_slave_sync |=> (cnt_r == CNT_ZERO) && (pre_r == CNT_ZERO);
  endproperty
  a_slave_restart: assert property (p_slave_restart) else $error("slave did not restart");

  property p_slave_load;
    @(posedge i_clock) disable iff (i_sys_rst)
    s_slave_sync ##0 i_xfer_in |=> per_sh_r == $past(i_period);
  endproperty
  a_slave_load: assert property (p_slave_load) else $error("slave shadow not loaded");

  property p_no_delay_sync;
    @(posedge i_clock) disable iff (i_sys_rst)
    (start && i_sync_delay == DLY_ZERO) |=> o_sync_out;
  endproperty
  a_no_delay_sync: assert property (p_no_delay_sync) else $error("sync pulse missing");

  property p_trap_hold;
    @(posedge i_clock) disable iff (i_sys_rst)
    trp_s2_r |=> ##1 o_modulated_outputs == $past(i_trap_level);
  endproperty
  a_trap_hold: assert property (p_trap_hold) else $error("outputs not held in stop");

  property p_capture;
    @(posedge i_clock) disable iff (i_sys_rst)
    (cap_s2_r[0] && !cap_s3_r[0]) |=> o_capture_event[0] && o_capture_value[CNT_W-1:0] == $past(cnt_r);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_count_bound;
    @(posedge i_clock) disable iff (i_sys_rst)
    !i_slave_mode && i_enable && run_r |-> cnt_r <= per_sh_r || $past(xfer);
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("counter beyond period");
endmodule : pms_core
`default_nettype wire

// ==== pms_pkg.sv ====
package pms_pkg;
  localparam int                 CNT_W      = 16;         // prescale and period counter width
  localparam int                 NUM_CAP    = 3;          // capture inputs 0..2
  localparam int                 NUM_MAT    = 6;          // match outputs 0..5
  localparam int                 DLY_W      = 8;          // sync-out delay width
  localparam logic [CNT_W-1:0]   CNT_ZERO   = 16'h0000;
  localparam logic [CNT_W-1:0]   CNT_ONE    = 16'h0001;
  localparam logic [DLY_W-1:0]   DLY_ZERO   = 8'h00;
  localparam logic [DLY_W-1:0]   DLY_ONE    = 8'h01;
  localparam logic [NUM_MAT-1:0] MAT_RESET  = 6'h00;

  typedef enum logic [1:0] {
    PMS_DLY_IDLE = 2'b00,
    PMS_DLY_WAIT = 2'b01
  } pms_dly_e;
endpackage : pms_pkg

// ==== pms_sync_delay.sv ====
`timescale 1ns/10ps
`default_nettype none
// delays the period-start and transfer-indicate pair by a programmable count
module pms_sync_delay
  import pms_pkg::*;
(
  input  wire logic             i_clock,      // subsystem clock
  input  wire logic             i_sys_rst,    // async reset, active high
  input  wire logic [DLY_W-1:0] i_delay,      // delay in cycles, zero passes through next cycle
  input  wire logic             i_start,      // counter start pulse
  input  wire logic             i_xfer,       // shadow copy happened with this start
  output logic                  o_sync,       // delayed period-start pulse
  output logic                  o_xfer        // delayed transfer-indicate pulse
);
  pms_dly_e         state_r, state_nxt;
  logic [DLY_W-1:0] cnt_r, cnt_nxt;
  logic             xfer_r, xfer_nxt;
  logic             sync_r, sync_nxt;
  logic             txo_r, txo_nxt;

  // a new start during a pending delay restarts it; only one pulse pair in flight
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    xfer_nxt  = xfer_r;
    sync_nxt  = 1'b0;
    txo_nxt   = 1'b0;
    if (i_start && i_delay == DLY_ZERO) begin
      sync_nxt  = 1'b1;
      txo_nxt   = i_xfer;
      state_nxt = PMS_DLY_IDLE;
    end else if (i_start) begin
      state_nxt = PMS_DLY_WAIT;
      cnt_nxt   = i_delay;
      xfer_nxt  = i_xfer;
    end else begin
      case (state_r)
        PMS_DLY_IDLE: begin
        end
        PMS_DLY_WAIT: begin
          if (cnt_r == DLY_ONE) begin
            sync_nxt  = 1'b1;
            txo_nxt   = xfer_r;
            state_nxt = PMS_DLY_IDLE;
          end
          cnt_nxt = cnt_r - DLY_ONE;
        end
        default: state_nxt = PMS_DLY_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= PMS_DLY_IDLE;
      cnt_r   <= DLY_ZERO;
      xfer_r  <= 1'b0;
      sync_r  <= 1'b0;
      txo_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      xfer_r  <= xfer_nxt;
      sync_r  <= sync_nxt;
      txo_r   <= txo_nxt;
    end
  end

  assign o_sync = sync_r;
  assign o_xfer = txo_r;

  property p_xfer_with_sync;
    @(posedge i_clock) disable iff (i_sys_rst)
    o_xfer |-> o_sync;
  endproperty
  a_xfer_with_sync: assert property (p_xfer_with_sync) else $error("transfer pulse without sync pulse");

  property p_sync_one_cycle;
    @(posedge i_clock) disable iff (i_sys_rst)
    o_sync |=> !o_sync || $past(i_start);
  endproperty
  a_sync_one_cycle: assert property (p_sync_one_cycle) else $error("sync pulse longer than one cycle");
endmodule : pms_sync_delay
`default_nettype wire

// ==== pms_upstream_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// upstream neighbour acting as master: registered one-cycle sync pair on the shared clock
module pms_upstream_model (
  input  wire logic i_clock,     // shared subsystem clock
  input  wire logic i_sys_rst,   // async reset, active high
  input  wire logic i_fire,      // bench asks for one period start
  input  wire logic i_with_xfer, // shadow copy goes with this start
  output logic      o_sync,      // period-start pulse to the slave
  output logic      o_xfer       // transfer-indicate pulse to the slave
);
  logic sync_nxt;
  logic xfer_nxt;

  always_comb begin
    sync_nxt = i_fire;
    xfer_nxt = i_fire & i_with_xfer;
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sync <= 1'b0;
      o_xfer <= 1'b0;
    end else begin
      o_sync <= sync_nxt;
      o_xfer <= xfer_nxt;
    end
  end
endmodule : pms_upstream_model
`default_nettype wire

// ==== pwm_master_slave_sync_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module pwm_master_slave_sync_tb_top;
  import pms_pkg::*;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, slv = 1'b0, upd = 1'b0, tclr = 1'b0, tie = 1'b0, stp = 1'b0;
  logic fire = 1'b0, wx = 1'b0, s_in, x_in, s_out, x_out, trapped, irq, pend;
  logic [CNT_W-1:0] pre = 16'h0001, per = 16'h0003;
  logic [NUM_MAT*CNT_W-1:0] rise = '0, fall = '0;
  logic [DLY_W-1:0] dly = 8'h00;
  logic [NUM_MAT-1:0] tlev = 6'h2d, mo;
  logic [NUM_CAP-1:0] cap = 3'h0, cev;
  logic [NUM_CAP*CNT_W-1:0] cval;
  int bad_count = 0, samples_checked = 0, cyc = 0, n, l0;

  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  pms_upstream_model i_pms_upstream_model (.i_clock(clk), .i_sys_rst(rst), .i_fire(fire), .i_with_xfer(wx),
    .o_sync(s_in), .o_xfer(x_in));
  pms_core i_pms_core (.i_clock(clk), .i_sys_rst(rst), .i_enable(en), .i_slave_mode(slv), .i_prescale(pre),
    .i_period(per), .i_rise(rise), .i_fall(fall), .i_update_req(upd), .i_sync_delay(dly), .i_trap_level(tlev),
    .i_trap_int_en(tie), .i_trap_clear(tclr), .i_sync_in(s_in), .i_xfer_in(x_in), .i_capture_inputs(cap),
    .i_protective_stop_input(stp), .o_modulated_outputs(mo), .o_sync_out(s_out), .o_xfer_out(x_out),
    .o_capture_value(cval), .o_capture_event(cev), .o_trapped(trapped), .o_trap_irq(irq),
    .o_update_pending(pend));

  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask : tick
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t %s: got %b exp %b", $time, msg, got, exp);
    end
  endtask : chk_bit
  task automatic chk_num(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t %s: got %0d exp %0d", $time, msg, got, exp);
    end
  endtask : chk_num
  // counts negedges until the outgoing start pulse shows, bounded
  task automatic wait_sync(input int lim, output int cnt);
    cnt = 0;
    while (s_out !== 1'b1 && cnt < lim) begin
      tick(1);
      cnt++;
    end
  endtask : wait_sync
  task automatic restart(input logic slave, input logic [DLY_W-1:0] d, output int lat);
    en = 1'b0;
    slv = slave;
    dly = d;
    // shadows come out of reset at zero; stage a copy so the first start loads the period
    upd = 1'b1;
    tick(1);
    upd = 1'b0;
    tick(1);
    en = 1'b1;
    wait_sync(40, lat);
  endtask : restart

  task automatic t_master_period();
    restart(1'b0, 8'h00, l0);
    tick(1);
    chk_bit(s_out, 1'b0, "start pulse too long");
    wait_sync(40, n);
    chk_num(n + 1, (pre + 1) * (per + 1), "period between starts");
    $display("test master_period done");
  endtask : t_master_period
  task automatic t_delay();
    restart(1'b0, 8'h03, n);
    chk_num(n - l0, 3, "added sync delay");
    tick(1);
    wait_sync(40, n);
    chk_num(n + 1, (pre + 1) * (per + 1), "period with delay");
    $display("test delay done");
  endtask : t_delay
  task automatic t_xfer();
    restart(1'b0, 8'h00, n);
    tick(2);
    upd = 1'b1;
    tick(1);
    upd = 1'b0;
    chk_bit(pend, 1'b1, "copy pending");
    wait_sync(40, n);
    chk_bit(x_out, 1'b1, "transfer pulse with copy");
    tick(1);
    chk_bit(pend, 1'b0, "pending cleared");
    wait_sync(40, n);
    chk_bit(x_out, 1'b0, "transfer pulse without copy");
    $display("test xfer done");
  endtask : t_xfer
  task automatic t_match();
    per = 16'h0007;
    for (int g = 0; g < NUM_MAT; g++) begin
      rise[g*CNT_W+:CNT_W] = 16'h0001;
      fall[g*CNT_W+:CNT_W] = 16'h0004;
    end
    restart(1'b0, 8'h00, n);
    upd = 1'b1;
    tick(1);
    upd = 1'b0;
    repeat (2) begin
      tick(1);
      wait_sync(80, n);
    end
    l0 = 0;
    n = 0;
    for (int c = 0; c < 16; c++) begin
      tick(1);
      l0 |= mo;
      n |= ~mo & 6'h3f;
    end
    chk_num(l0, 6'h3f, "each output goes high");
    chk_num(n, 6'h3f, "each output goes low");
    $display("test match done");
  endtask : t_match
  task automatic t_slave();
    per = 16'h0100;
    pre = 16'h0000;
    restart(1'b1, 8'h00, n);
    tick(12);
    wait_sync(400, n);
    chk_num(n, 400, "slave restarted without upstream");
    for (int i = 0; i < NUM_CAP; i++) begin
      wx = i[0];
      fire = 1'b1;
      tick(1);
      fire = 1'b0;
      wait_sync(10, n);
      chk_bit(s_out, 1'b1, "slave forwards start");
      chk_bit(x_out, i[0], "slave forwards transfer");
      cap[i] = 1'b1;
      tick(2);
      cap[i] = 1'b0;
      n = 0;
      while (cev[i] !== 1'b1 && n < 8) begin
        tick(1);
        n++;
      end
      chk_bit(cev[i], 1'b1, "capture event");
      chk_num(cev, 1 << i, "only one capture");
      chk_bit(cval[i*CNT_W+:CNT_W] < 16'h0010, 1'b1, "counter restarted from zero");
    end
    $display("test slave done");
  endtask : t_slave
  task automatic t_trap(input logic ie);
    tie = ie;
    stp = 1'b1;
    tick(6);
    chk_bit(trapped, 1'b1, "protective state");
    chk_num(mo, tlev, "held output levels");
    chk_bit(irq, ie, "stop interrupt");
    stp = 1'b0;
    tick(4);
    tclr = 1'b1;
    tick(1);
    tclr = 1'b0;
    tick(2);
    chk_bit(trapped, 1'b0, "stop cleared");
    $display("test trap done");
  endtask : t_trap

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  initial begin
    tick(16);
    rst = 1'b0;
    tick(1);
    t_master_period();
    t_delay();
    t_xfer();
    t_match();
    t_slave();
    t_trap(1'b1);
    t_trap(1'b0);
    tally_and_finish();
  end
endmodule : pwm_master_slave_sync_tb_top
`default_nettype wire
